// [hw/jtidr_top.v]
// Test access port with identification, bypass and boundary scan registers
`timescale 1ns/1ps
`default_nettype none
`include "jtidr_regs.vh"
// How it works
// - Identification instruction routes the identity register to serial out.
// - Under that instruction, Capture-DR loads the identity word.
// - Shift-DR moves the captured identity word out one bit per rising edge.
// - Test-Logic-Reset forces identification into the current instruction.
// - Identity bit zero is always one.
// - Identity bits eleven to one carry the eleven-bit manufacturer field.
// - Identity bits twenty-seven to twelve carry the sixteen-bit part code.
// - Identity bits thirty-one to twenty-eight carry the silicon revision.
// - Identity register has a 32-bit shift stage and a 32-bit latch.
// - Identity register selected by its code and in Test-Logic-Reset.
// - One-bit bypass stage serves bypass, clamp and high-impedance codes.
// - Boundary register has a shift path and a latched parallel output.
// - Three-state cell enabled by the cell below; observe cells follow.
// - Bypass, boundary and identification registers are all present.
// - Instruction register is three bits; code 001 selects identification.
// - Power-up starts in Test-Logic-Reset with identification current.
module jtidr_top #(
    parameter [`JTIDR_REV_W-1:0]   REVISION  = 4'h0,    // Arbitrary
    parameter [`JTIDR_PART_W-1:0]  PART_CODE = 16'h1234, // Arbitrary value
    parameter [`JTIDR_MAKER_W-1:0] MAKER     = 11'h055  // Arbitrary value
) (
    input  wire                       clock,
    input  wire                       rst_n,
    input  wire                       test_clock_pin,
    input  wire                       test_mode_select_pin,
    input  wire                       test_serial_in_pin,
    input  wire [`JTIDR_BSR_LEN-1:0]  bsr_pin_in,
    output reg                        test_serial_out_pin,
    output reg                        test_serial_out_oe,
    output reg  [`JTIDR_IR_W-1:0]     current_instr,
    output reg  [`JTIDR_ID_W-1:0]     id_parallel,
    output reg  [`JTIDR_BSR_LEN-1:0]  bsr_pin_out,
    output reg  [`JTIDR_BSR_LEN-1:0]  bsr_pin_oe,
    output reg                        test_owns_pins
);
    localparam [3:0] ST_RESET  = 4'h0;
    localparam [3:0] ST_IDLE   = 4'h1;
    localparam [3:0] ST_SEL_DR = 4'h2;
    localparam [3:0] ST_CAP_DR = 4'h3;
    localparam [3:0] ST_SH_DR  = 4'h4;
    localparam [3:0] ST_EX1_DR = 4'h5;
    localparam [3:0] ST_PA_DR  = 4'h6;
    localparam [3:0] ST_EX2_DR = 4'h7;
    localparam [3:0] ST_UP_DR  = 4'h8;
    localparam [3:0] ST_SEL_IR = 4'h9;
    localparam [3:0] ST_CAP_IR = 4'ha;
    localparam [3:0] ST_SH_IR  = 4'hb;
    localparam [3:0] ST_EX1_IR = 4'hc;
    localparam [3:0] ST_PA_IR  = 4'hd;
    localparam [3:0] ST_EX2_IR = 4'he;
    localparam [3:0] ST_UP_IR  = 4'hf;

    localparam SYNC_W = `JTIDR_BSR_LEN + 3;
    // Mask held at the register length so it can be indexed per cell
    localparam [`JTIDR_BSR_LEN-1:0] OUT3_MASK = `JTIDR_BSR_OUT3;

    // Identity word assembled from its fields
    wire [`JTIDR_ID_W-1:0] id_word = {REVISION,
                                      PART_CODE,
                                      MAKER,
                                      `JTIDR_ID_LSB};

    wire [SYNC_W-1:0] synced;
    wire              tck_s = synced[0];
    wire              tms_s = synced[1];
    wire              tdi_s = synced[2];
    wire [`JTIDR_BSR_LEN-1:0] pins_s = synced[SYNC_W-1:3];

    reg                       tck_d;
    reg  [3:0]                state;
    reg  [3:0]                next_state;
    reg  [`JTIDR_IR_W-1:0]    ir_shift;
    reg  [`JTIDR_ID_W-1:0]    id_shift;
    reg                       bypass_bit;
    reg  [`JTIDR_BSR_LEN-1:0] bsr_shift;
    reg  [`JTIDR_BSR_LEN-1:0] bsr_latch;
    reg                       next_tdo;
    reg  [`JTIDR_BSR_LEN-1:0] next_oe;
    integer                   i;

    // Test pins and observed pins come from another clock domain
    jtidr_sync #(
        .WIDTH    (SYNC_W)
    ) u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in ({bsr_pin_in, test_serial_in_pin,
                    test_mode_select_pin, test_clock_pin}),
        .sync_out (synced)
    );

    wire tck_rise = tck_s & ~tck_d;
    wire tck_fall = ~tck_s & tck_d;

    // Register selection by current instruction; identity also in reset
    wire sel_id  = (current_instr == `JTIDR_IR_IDCODE);
    wire sel_bsr = (current_instr == `JTIDR_IR_EXTEST) ||
                   (current_instr == `JTIDR_IR_SAMPLE);
    wire sel_byp = !sel_id && !sel_bsr;  // Unlisted codes also take bypass

    // Controller next state, advanced on test clock rising edges
    always @* begin
        case (state)
            ST_RESET:  next_state = tms_s ? ST_RESET  : ST_IDLE;
            ST_IDLE:   next_state = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tms_s ? ST_UP_DR  : ST_PA_DR;
            ST_PA_DR:  next_state = tms_s ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: next_state = tms_s ? ST_UP_DR  : ST_SH_DR;
            ST_UP_DR:  next_state = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms_s ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tms_s ? ST_UP_IR  : ST_PA_IR;
            ST_PA_IR:  next_state = tms_s ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: next_state = tms_s ? ST_UP_IR  : ST_SH_IR;
            ST_UP_IR:  next_state = tms_s ? ST_SEL_DR : ST_IDLE;
            default:   next_state = ST_RESET;
        endcase
    end

    // Serial output value for the falling edge, picked by the active path
    always @* begin
        next_tdo = 1'b0;
        if (state == ST_SH_IR) begin
            next_tdo = ir_shift[0];
        end else if (sel_id) begin
            next_tdo = id_shift[0];
        end else if (sel_bsr) begin
            next_tdo = bsr_shift[0];
        end else begin
            next_tdo = bypass_bit;
        end
    end

    // Three-state cells take their enable from the cell just below
    always @* begin
        next_oe = {`JTIDR_BSR_LEN{1'b0}};
        for (i = 1; i < `JTIDR_BSR_LEN; i = i + 1) begin
            if (OUT3_MASK[i]) begin
                next_oe[i] = bsr_latch[i-1];
            end
        end
        if (current_instr == `JTIDR_IR_HIGHZ ||
            !(current_instr == `JTIDR_IR_EXTEST ||
              current_instr == `JTIDR_IR_CLAMP)) begin
            next_oe = {`JTIDR_BSR_LEN{1'b0}};
        end
    end

    // Controller state and edge history
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tck_d <= 1'b0;
            state <= ST_RESET;
        end else begin
            tck_d <= tck_s;
            if (tck_rise) begin
                state <= next_state;
            end
        end
    end

    // Capture and shift happen on rising edges of the test clock
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ir_shift   <= {`JTIDR_IR_W{1'b0}};
            id_shift   <= {`JTIDR_ID_W{1'b0}};
            bypass_bit <= 1'b0;
            bsr_shift  <= {`JTIDR_BSR_LEN{1'b0}};
        end else if (tck_rise) begin
            case (state)
                ST_CAP_IR: begin
                    ir_shift <= `JTIDR_IR_CAPTURE;
                end
                ST_SH_IR: begin
                    ir_shift <= {tdi_s, ir_shift[`JTIDR_IR_W-1:1]};
                end
                ST_CAP_DR: begin
                    if (sel_id) begin
                        id_shift <= id_word;
                    end
                    if (sel_bsr) begin
                        // Observe cells read pins, others keep their value
                        bsr_shift <= (pins_s & `JTIDR_BSR_OBS) |
                                     (bsr_shift & ~`JTIDR_BSR_OBS);
                    end
                    if (sel_byp) begin
                        bypass_bit <= 1'b0;
                    end
                end
                ST_SH_DR: begin
                    if (sel_id) begin
                        id_shift <= {tdi_s, id_shift[`JTIDR_ID_W-1:1]};
                    end
                    if (sel_bsr) begin
                        bsr_shift <= {tdi_s, bsr_shift[`JTIDR_BSR_LEN-1:1]};
                    end
                    if (sel_byp) begin
                        bypass_bit <= tdi_s;
                    end
                end
                default: begin
                    ir_shift <= ir_shift;
                end
            endcase
        end
    end

    // Updates and serial output change on falling edges of the test clock
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            current_instr       <= `JTIDR_IR_IDCODE;
            id_parallel         <= {`JTIDR_ID_W{1'b0}};
            bsr_latch           <= {`JTIDR_BSR_LEN{1'b0}};
            test_serial_out_pin <= 1'b0;
            test_serial_out_oe  <= 1'b0;
        end else begin
            if (state == ST_RESET) begin
                current_instr <= `JTIDR_IR_IDCODE;
            end else if (tck_fall && state == ST_UP_IR) begin
                current_instr <= ir_shift;
            end
            if (tck_fall && state == ST_UP_DR) begin
                // Latches keep parallel outputs still while shifting
                if (sel_id) begin
                    id_parallel <= id_shift;
                end
                if (sel_bsr) begin
                    bsr_latch <= bsr_shift;
                end
            end
            if (tck_fall) begin
                test_serial_out_pin <= next_tdo;
                test_serial_out_oe  <= (state == ST_SH_DR) ||
                                       (state == ST_SH_IR);
            end
        end
    end

    // Pin drive follows the latched boundary cells in the test modes
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bsr_pin_out    <= {`JTIDR_BSR_LEN{1'b0}};
            bsr_pin_oe     <= {`JTIDR_BSR_LEN{1'b0}};
            test_owns_pins <= 1'b0;
        end else begin
            bsr_pin_out    <= bsr_latch & `JTIDR_BSR_OUT3;
            bsr_pin_oe     <= next_oe;
            test_owns_pins <= (current_instr == `JTIDR_IR_EXTEST) ||
                              (current_instr == `JTIDR_IR_CLAMP) ||
                              (current_instr == `JTIDR_IR_HIGHZ);
        end
    end
endmodule
`default_nettype wire

// [hw/jtidr_regs.vh]
// Instruction codes, identity layout and boundary cell map for the test port
`ifndef JTIDR_REGS_VH
`define JTIDR_REGS_VH

`define JTIDR_IR_W          3
`define JTIDR_IR_EXTEST     3'h0
`define JTIDR_IR_IDCODE     3'h1
`define JTIDR_IR_SAMPLE     3'h2
`define JTIDR_IR_CLAMP      3'h3
`define JTIDR_IR_HIGHZ      3'h4
`define JTIDR_IR_BYPASS     3'h7
`define JTIDR_IR_CAPTURE    3'h1

`define JTIDR_ID_W          32
`define JTIDR_ID_LSB        1'h1
`define JTIDR_MAKER_W       11
`define JTIDR_PART_W        16
`define JTIDR_REV_W         4

`define JTIDR_BSR_LEN       20
// One bit per cell: set where the cell drives a three-state output
`define JTIDR_BSR_OUT3      20'h2124a
// One bit per cell: set where the cell is observe-only
`define JTIDR_BSR_OBS       20'h4e490

`endif

// [hw/jtidr_sync.v]
// Two-flop synchroniser for inputs arriving from outside the system clock
`timescale 1ns/1ps
`default_nettype none
module jtidr_sync #(
    parameter WIDTH = 1
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// [testbench/jtidr_chk_props.sv]
// Concurrent checks on the test port outputs
`timescale 1ns/1ps
`default_nettype none
`include "jtidr_regs.vh"
module jtidr_chk (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        test_clock_pin,
    input wire logic        test_serial_out_pin,
    input wire logic        test_serial_out_oe,
    input wire logic [2:0]  current_instr,
    input wire logic [31:0] id_parallel,
    input wire logic [19:0] bsr_pin_out,
    input wire logic [19:0] bsr_pin_oe,
    input wire logic        test_owns_pins
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    boot_instr_a: assert property ($rose(rst_n)
        |-> current_instr == `JTIDR_IR_IDCODE)
        else $error("instruction not identity after reset");
    oe_cells_a: assert property (
        (bsr_pin_oe & ~`JTIDR_BSR_OUT3) == 20'h0)
        else $error("enable on a cell that is not three-state");
    out_cells_a: assert property (
        (bsr_pin_out & ~`JTIDR_BSR_OUT3) == 20'h0)
        else $error("drive on a cell that is not three-state");
    highz_off_a: assert property (
        (current_instr == `JTIDR_IR_HIGHZ) [*2] |-> bsr_pin_oe == 20'h0)
        else $error("enable set under high-z");
    owns_pins_a: assert property (
        (current_instr inside {3'h0, 3'h3, 3'h4}) [*2] |-> test_owns_pins)
        else $error("pins not taken over");
    // Serial outputs move only in the low phase, a few clocks after a fall
    tdo_phase_a: assert property ($changed(test_serial_out_pin)
        |-> !test_clock_pin) else $error("serial out moved while clock high");
    oe_phase_a: assert property ($changed(test_serial_out_oe)
        |-> !test_clock_pin) else $error("serial enable moved while clock high");
    id_latch_a: assert property ($changed(id_parallel)
        |-> !test_clock_pin && !test_serial_out_oe)
        else $error("identity latch moved outside update");
    instr_upd_a: assert property ($changed(current_instr)
        |-> !test_clock_pin || current_instr == `JTIDR_IR_IDCODE)
        else $error("instruction moved outside update or reset state");
endmodule
`default_nettype wire

// [testbench/jtidr_ctl.sv]
// Behavioural boundary-scan controller driving the test pins
`timescale 1ns/1ps
`default_nettype none
module jtidr_ctl (
    input  wire logic clock,
    input  wire logic tdo_line,
    output var  logic test_clock_pin,
    output var  logic test_mode_select_pin,
    output var  logic test_serial_in_pin
);
    initial begin
        test_clock_pin = 1'b0;
        test_mode_select_pin = 1'b1;
        test_serial_in_pin = 1'b1;
    end
    // One 160 ns test clock; idles low between calls, inputs settle 40 ns
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        repeat (4) @(posedge clock);
        #1;
        test_mode_select_pin = tms;
        test_serial_in_pin = tdi;
        repeat (4) @(posedge clock);
        #1;
        tdo = tdo_line;
        test_clock_pin = 1'b1;
        repeat (8) @(posedge clock);
        #1;
        test_clock_pin = 1'b0;
    endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the test port data registers
`timescale 1ns/1ps
`default_nettype none
`include "jtidr_regs.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    localparam [3:0]  REV   = 4'h9;     // Arbitrary value
    localparam [15:0] PART  = 16'h5a3c; // Arbitrary value
    localparam [10:0] MAKER = 11'h2b7;  // Arbitrary value
    localparam [31:0] ID    = {REV, PART, MAKER, 1'b1};
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [19:0] bsr_pin_in = 20'h0;
    logic        test_clock_pin, test_mode_select_pin, test_serial_in_pin;
    logic        test_serial_out_pin, test_serial_out_oe, test_owns_pins;
    logic [2:0]  current_instr;
    logic [31:0] id_parallel, din, dout;
    logic [19:0] bsr_pin_out, bsr_pin_oe, lat;
    int          err_count = 0, cmp_count = 0, cycles = 0, seed = 20;
    // Released serial line floats to the pull-up level
    wire logic tdo_line = test_serial_out_oe ? test_serial_out_pin : 1'b1;

    always #5 clock = ~clock;

    jtidr_top #(.REVISION(REV), .PART_CODE(PART), .MAKER(MAKER)) jtidr_top_i (
        .clock(clock), .rst_n(rst_n), .test_clock_pin(test_clock_pin),
        .test_mode_select_pin(test_mode_select_pin),
        .test_serial_in_pin(test_serial_in_pin), .bsr_pin_in(bsr_pin_in),
        .test_serial_out_pin(test_serial_out_pin),
        .test_serial_out_oe(test_serial_out_oe),
        .current_instr(current_instr), .id_parallel(id_parallel),
        .bsr_pin_out(bsr_pin_out), .bsr_pin_oe(bsr_pin_oe),
        .test_owns_pins(test_owns_pins));
    jtidr_ctl jtidr_ctl_i (.clock(clock), .tdo_line(tdo_line),
        .test_clock_pin(test_clock_pin),
        .test_mode_select_pin(test_mode_select_pin),
        .test_serial_in_pin(test_serial_in_pin));

    // Each enable comes from the control cell just below its cell
    function automatic logic [19:0] exp_oe(input logic [19:0] d);
        exp_oe = (d << 1) & `JTIDR_BSR_OUT3;
    endfunction
    // Observe cells take the pin level, the other cells keep their value
    function automatic logic [19:0] cap_exp(input logic [19:0] p, k);
        cap_exp = (p & `JTIDR_BSR_OBS) | (k & ~`JTIDR_BSR_OBS);
    endfunction
    // Mode-select pattern, first step in the low bit, random data in
    task automatic walk(input logic [7:0] tms, input int n);
        logic s;
        for (int i = 0; i < n; i++)
            jtidr_ctl_i.step(tms[i], 1'($random(seed)), s);
    endtask
    task automatic ir_load(input logic [2:0] code);
        logic s;
        walk(8'h03, 4);
        for (int i = 0; i < 3; i++)
            jtidr_ctl_i.step(i == 2, code[i], s);
        walk(8'h01, 2);
    endtask
    // Data scan from idle back to idle with random data in
    task automatic dr_scan(input int n);
        din = $random(seed);
        dout = 32'h0;
        bsr_pin_in = 20'($random(seed));
        walk(8'h01, 3);
        for (int i = 0; i < n; i++)
            jtidr_ctl_i.step(i == n - 1, din[i], dout[i]);
        walk(8'h01, 2);
    endtask
    task automatic give_verdict;
        if (err_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Run takes some 5850 cycles; the ceiling leaves ample margin
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            give_verdict;
        end
    end

    initial begin
        repeat (4) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clock);
        `CHK(current_instr, 3'h1)
        walk(8'h00, 1);
        dr_scan(32);
        `CHK(dout[0], 1'b1)
        `CHK(dout[11:1], MAKER)
        `CHK(dout[27:12], PART)
        `CHK(dout[31:28], REV)
        `CHK(id_parallel, din)
        lat = 20'h0;
        for (int k = 0; k < 8; k++) begin
            ir_load(3'(k));
            `CHK(current_instr, 3'(k))
            dr_scan(k == 1 ? 32 : 20);
            if (k == 0 || k == 2)
                `CHK(dout[19:0], cap_exp(bsr_pin_in, lat))
            if (k == 0 || k == 2) lat = din[19:0];
            `CHK(test_owns_pins, k == 0 || k == 3 || k == 4)
            `CHK(bsr_pin_out, lat & `JTIDR_BSR_OUT3)
            `CHK(bsr_pin_oe, (k == 0 || k == 3) ? exp_oe(lat) : 20'h0)
            if (k == 1) `CHK(dout, ID)
            if (k > 2) `CHK(dout[19:0], {din[18:0], 1'b0})
        end
        walk(8'h1f, 5);
        `CHK(current_instr, 3'h1)
        walk(8'h00, 1);
        dr_scan(32);
        `CHK(dout, ID)
        give_verdict;
    end
endmodule

bind jtidr_top jtidr_chk jtidr_chk_i (
    .clock(clock), .rst_n(rst_n), .test_clock_pin(test_clock_pin),
    .test_serial_out_pin(test_serial_out_pin),
    .test_serial_out_oe(test_serial_out_oe), .current_instr(current_instr),
    .id_parallel(id_parallel), .bsr_pin_out(bsr_pin_out),
    .bsr_pin_oe(bsr_pin_oe), .test_owns_pins(test_owns_pins));
`default_nettype wire
